/* File: design/pdm_defs.svh */
/*
  Register offsets, field positions, reset values and wait counts of the
  power-down mode control block. Included by bare name; definitions only.
*/
`ifndef PDM_DEFS_SVH
`define PDM_DEFS_SVH

// ==========================================================================
// Register map
`define PDM_ADDR_W 4
`define PDM_OFF_CTRL_ONE 4'h0
`define PDM_OFF_CTRL_TWO 4'h1
`define PDM_OFF_STATUS 4'h2
`define PDM_OFF_CMD 4'h3

// ==========================================================================
// Control register one fields
`define PDM_BIT_DEEP_STANDBY 7
`define PDM_BIT_WAIT_HI 6
`define PDM_BIT_WAIT_LO 4
`define PDM_BIT_LOW_SPEED 3
`define PDM_BIT_TIMER_MODE 2
`define PDM_BIT_MDIV_HI 1
`define PDM_BIT_MDIV_LO 0
`define PDM_RST_CTRL_ONE 8'h03

// ==========================================================================
// Control register two fields
`define PDM_BIT_DIRECT 3
`define PDM_BIT_MEDIUM 2
`define PDM_RST_CTRL_TWO 8'h00

// ==========================================================================
// Command register bits
`define PDM_BIT_CMD_SLEEP 0
`define PDM_BIT_CMD_WAKE 1

// ==========================================================================
// Wait counts in states
`define PDM_WAIT_W 15
`define PDM_WAIT_0 15'h2000
`define PDM_WAIT_1 15'h4000
`define PDM_WAIT_2 15'h0400
`define PDM_WAIT_3 15'h0800
`define PDM_WAIT_4 15'h1000
`define PDM_WAIT_5 15'h0100
`define PDM_WAIT_6 15'h0200
`define PDM_WAIT_7 15'h0010

`endif

/* File: design/pdm_pkg.sv */
/*
  Types of the power-down mode control block.
  Assumes nothing of its surroundings.
*/
package pdm_pkg;

  // ==========================================================================
  // Operating modes
  typedef enum logic [2:0] {
    PDM_ACTIVE_HIGH,
    PDM_ACTIVE_MEDIUM,
    PDM_SUBACTIVE,
    PDM_SLEEP,
    PDM_SUBSLEEP,
    PDM_WATCH,
    PDM_STANDBY
  } pdm_mode_t;

  // ==========================================================================
  // Wait sequencer states
  typedef enum logic [1:0] {
    PDM_RUN,
    PDM_LOW,
    PDM_WAIT
  } pdm_seq_t;

endpackage

/* File: design/pdm_wait_if.sv */
/*
  Interface between mode controller and its wait counter.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none

interface pdm_wait_if;
  logic start;
  logic [14:0] count;
  logic done;
  modport ctrl (output start, output count, input done);
  modport cnt (input start, input count, output done);
endinterface

`default_nettype wire

/* File: design/pdm_wait_counter.sv */
/*
  Oscillation stabilization wait counter.
  Assumes start is a one-cycle pulse and count is stable while running.
*/
`timescale 1ns/100ps
`default_nettype none

module pdm_wait_counter #(
  parameter int WIDTH = 15
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Controller link
  pdm_wait_if.cnt wt
);

  initial begin
    if (WIDTH != 15) $error("pdm_wait_counter: WIDTH must be 15");
  end

  logic [WIDTH-1:0] remain_q;
  logic busy_q;
  logic done_q;

  // ==========================================================================
  // Count states, then pulse done
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      remain_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (wt.start) begin
        remain_q <= wt.count - 15'h0001;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (remain_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          remain_q <= remain_q - 15'h0001;
        end
      end
    end
  end

  assign wt.done = done_q;

endmodule // pdm_wait_counter

`default_nettype wire

/* File: design/pdm_mode_ctrl.sv */
/*
  Power-down mode control: control registers, sleep target decode,
  oscillator wait sequencing and medium-speed divider selection.
  Assumes a CPU-side register port and sleep and wake strobes on core_clk.
*/
// Notes on behaviour
// - Deep standby bit picks standby/watch over sleep
// - Wait codes 0-3 give 8192,16384,1024,2048
// - Wait codes 4-7 give 4096,256,512,16
// - Wait holds CPU and peripherals on wake
// - Low-speed bit picks subclock after watch
// - Target mode decoded from five control bits
// - Divider code 00 is /8, 11 is /64
// - Middle divider codes give /16 and /32
`timescale 1ns/100ps
`default_nettype none
`include "pdm_defs.svh"

module pdm_mode_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // CPU events
  input wire logic sleep_exec,
  input wire logic wake_irq,
  // Clock control outputs
  output logic cpu_hold,
  output logic periph_hold,
  output logic osc_run,
  output logic sub_clk_sel,
  output logic [6:0] osc_div,
  output logic [2:0] mode_out
);

  // ==========================================================================
  // Registers
  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_two_q;
  pdm_pkg::pdm_mode_t mode_q;
  pdm_pkg::pdm_mode_t target_d;
  pdm_pkg::pdm_seq_t seq_q;
  logic sleep_q;
  logic wake_q;
  logic [14:0] wait_cnt_d;
  logic start_q;
  logic [6:0] div_d;
  logic [7:0] rdata_q;

  pdm_wait_if wt ();

  pdm_wait_counter #(
    .WIDTH(15)
  ) u_wait (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .wt(wt)
  );

  wire logic deep_standby_select = ctrl_one_q[`PDM_BIT_DEEP_STANDBY];
  wire logic low_speed_wake_select = ctrl_one_q[`PDM_BIT_LOW_SPEED];
  wire logic timer_mode_select = ctrl_one_q[`PDM_BIT_TIMER_MODE];
  wire logic direct_transfer_select = ctrl_two_q[`PDM_BIT_DIRECT];
  wire logic medium_speed_select = ctrl_two_q[`PDM_BIT_MEDIUM];
  wire logic [2:0] wait_sel = ctrl_one_q[`PDM_BIT_WAIT_HI:`PDM_BIT_WAIT_LO];
  wire logic [1:0] mdiv_sel = ctrl_one_q[`PDM_BIT_MDIV_HI:`PDM_BIT_MDIV_LO];

  // Divider field may change only in high-speed or subactive mode
  wire logic mdiv_ok = (mode_q == pdm_pkg::PDM_ACTIVE_HIGH) ||
                       (mode_q == pdm_pkg::PDM_SUBACTIVE);

  // ==========================================================================
  // Register writes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_one_q <= `PDM_RST_CTRL_ONE;
      ctrl_two_q <= `PDM_RST_CTRL_TWO;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `PDM_OFF_CTRL_ONE) begin
        ctrl_one_q[7:2] <= reg_wdata[7:2];
        if (mdiv_ok) begin
          ctrl_one_q[1:0] <= reg_wdata[1:0];
        end
      end
      if (reg_addr == `PDM_OFF_CTRL_TWO) begin
        ctrl_two_q <= {4'h0, reg_wdata[3:2], 2'h0};
      end
    end
  end

  // ==========================================================================
  // Register reads, data one cycle later
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `PDM_OFF_CTRL_ONE: rdata_q <= ctrl_one_q;
          `PDM_OFF_CTRL_TWO: rdata_q <= ctrl_two_q;
          `PDM_OFF_STATUS: rdata_q <= {3'h0, seq_q == pdm_pkg::PDM_WAIT, 1'b0, mode_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================================
  // Sleep target decode
  always_comb begin
    target_d = pdm_pkg::PDM_SLEEP;
    if (!deep_standby_select) begin
      if (mode_q == pdm_pkg::PDM_SUBACTIVE) begin
        target_d = pdm_pkg::PDM_SUBSLEEP;
      end else begin
        target_d = pdm_pkg::PDM_SLEEP;
      end
    end else if (timer_mode_select) begin
      target_d = pdm_pkg::PDM_WATCH;
    end else begin
      target_d = pdm_pkg::PDM_STANDBY;
    end
    if (direct_transfer_select && !deep_standby_select) begin
      if (mode_q == pdm_pkg::PDM_SUBACTIVE) begin
        target_d = medium_speed_select ? pdm_pkg::PDM_ACTIVE_MEDIUM :
                                         pdm_pkg::PDM_ACTIVE_HIGH;
      end else if (low_speed_wake_select) begin
        target_d = pdm_pkg::PDM_SUBACTIVE;
      end
    end
  end

  // ==========================================================================
  // Wait length per code
  always_comb begin
    case (wait_sel)
      3'h0: wait_cnt_d = `PDM_WAIT_0;
      3'h1: wait_cnt_d = `PDM_WAIT_1;
      3'h2: wait_cnt_d = `PDM_WAIT_2;
      3'h3: wait_cnt_d = `PDM_WAIT_3;
      3'h4: wait_cnt_d = `PDM_WAIT_4;
      3'h5: wait_cnt_d = `PDM_WAIT_5;
      3'h6: wait_cnt_d = `PDM_WAIT_6;
      default: wait_cnt_d = `PDM_WAIT_7;
    endcase
  end

  // ==========================================================================
  // Medium-speed divider
  always_comb begin
    case (mdiv_sel)
      2'h0: div_d = 7'h08;
      2'h1: div_d = 7'h10;
      2'h2: div_d = 7'h20;
      default: div_d = 7'h40;
    endcase
  end

  wire logic [6:0] div_use = (mode_q == pdm_pkg::PDM_ACTIVE_MEDIUM ||
                              (mode_q == pdm_pkg::PDM_SLEEP && medium_speed_select)) ?
                             div_d : 7'h01;

  // Command strobes from register or CPU ports
  wire logic cmd_wr = clk_en && reg_wr && (reg_addr == `PDM_OFF_CMD);
  wire logic sleep_req = sleep_exec || (cmd_wr && reg_wdata[`PDM_BIT_CMD_SLEEP]);
  wire logic wake_req = wake_irq || (cmd_wr && reg_wdata[`PDM_BIT_CMD_WAKE]);

  // ==========================================================================
  // Mode sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= pdm_pkg::PDM_ACTIVE_HIGH;
      seq_q <= pdm_pkg::PDM_RUN;
      start_q <= 1'b0;
    end else if (clk_en) begin
      start_q <= 1'b0;
      case (seq_q)
        pdm_pkg::PDM_RUN: begin
          if (sleep_req) begin
            mode_q <= target_d;
            if (target_d != pdm_pkg::PDM_ACTIVE_HIGH &&
                target_d != pdm_pkg::PDM_ACTIVE_MEDIUM &&
                target_d != pdm_pkg::PDM_SUBACTIVE) begin
              seq_q <= pdm_pkg::PDM_LOW;
            end
          end
        end
        pdm_pkg::PDM_LOW: begin
          if (wake_req) begin
            if (mode_q == pdm_pkg::PDM_WATCH && low_speed_wake_select) begin
              mode_q <= pdm_pkg::PDM_SUBACTIVE;
              seq_q <= pdm_pkg::PDM_RUN;
            end else if (mode_q == pdm_pkg::PDM_SUBSLEEP) begin
              mode_q <= pdm_pkg::PDM_SUBACTIVE;
              seq_q <= pdm_pkg::PDM_RUN;
            end else if (mode_q == pdm_pkg::PDM_SLEEP) begin
              // Medium bit picks the active speed after sleep as well
              mode_q <= medium_speed_select ? pdm_pkg::PDM_ACTIVE_MEDIUM :
                                              pdm_pkg::PDM_ACTIVE_HIGH;
              seq_q <= pdm_pkg::PDM_RUN;
            end else begin
              start_q <= 1'b1;
              seq_q <= pdm_pkg::PDM_WAIT;
            end
          end
        end
        pdm_pkg::PDM_WAIT: begin
          if (wt.done) begin
            mode_q <= medium_speed_select ? pdm_pkg::PDM_ACTIVE_MEDIUM :
                                            pdm_pkg::PDM_ACTIVE_HIGH;
            seq_q <= pdm_pkg::PDM_RUN;
          end
        end
        default: seq_q <= pdm_pkg::PDM_RUN;
      endcase
    end
  end

  assign wt.start = start_q;
  assign wt.count = wait_cnt_d;

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_hold <= 1'b0;
      periph_hold <= 1'b0;
      osc_run <= 1'b1;
      sub_clk_sel <= 1'b0;
      osc_div <= 7'h01;
      mode_out <= 3'h0;
    end else if (clk_en) begin
      cpu_hold <= (seq_q != pdm_pkg::PDM_RUN);
      periph_hold <= (seq_q == pdm_pkg::PDM_WAIT) ||
                     (seq_q == pdm_pkg::PDM_LOW && mode_q == pdm_pkg::PDM_STANDBY);
      osc_run <= !(seq_q == pdm_pkg::PDM_LOW &&
                   (mode_q == pdm_pkg::PDM_STANDBY || mode_q == pdm_pkg::PDM_WATCH ||
                    mode_q == pdm_pkg::PDM_SUBSLEEP)) && mode_q != pdm_pkg::PDM_SUBACTIVE;
      sub_clk_sel <= (mode_q == pdm_pkg::PDM_SUBACTIVE) ||
                     (mode_q == pdm_pkg::PDM_SUBSLEEP) ||
                     (mode_q == pdm_pkg::PDM_WATCH);
      osc_div <= div_use;
      mode_out <= mode_q;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // pdm_mode_ctrl

`default_nettype wire

/* File: verif/pdm_mode_sva.sv */
/*
  Port checker of the power-down mode control block.
  Assumes binding to pdm_mode_ctrl, one clock core_clk, nrst active low.
*/
`timescale 1ns/100ps
`default_nettype none

module pdm_mode_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Requests
  input wire logic sleep_exec,
  input wire logic wake_irq,
  // Outputs
  input wire logic cpu_hold,
  input wire logic periph_hold,
  input wire logic osc_run,
  input wire logic sub_clk_sel,
  input wire logic [6:0] osc_div,
  input wire logic [2:0] mode_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================================
  // Properties
  a_high_div: assert property (
    mode_out == 3'h0 && $stable(mode_out) |-> osc_div == 7'h01) else $error("high speed div");
  a_med_div: assert property (
    mode_out == 3'h1 && $stable(mode_out) |-> osc_div inside {7'h08, 7'h10, 7'h20, 7'h40})
    else $error("medium div");
  a_sub_clock: assert property (
    mode_out inside {3'h2, 3'h4, 3'h5} && $stable(mode_out) |-> sub_clk_sel)
    else $error("subclock select");
  a_hold_pair: assert property (
    periph_hold |-> cpu_hold) else $error("periph held, cpu free");
  a_standby_halt: assert property (
    mode_out == 3'h6 |-> cpu_hold && periph_hold && (!osc_run || $stable(mode_out)))
    else $error("standby not halted");
  a_lowpow_cpu: assert property (
    mode_out inside {3'h3, 3'h4, 3'h5, 3'h6} && $stable(mode_out) |-> cpu_hold)
    else $error("cpu runs in low power");
  a_wait_min: assert property (
    mode_out == 3'h6 && wake_irq && clk_en |=> cpu_hold [*8]) else $error("wait too short");
  a_sleep_leave: assert property (
    mode_out == 3'h3 && wake_irq && clk_en |-> ##[1:4] !cpu_hold) else $error("sleep exit slow");
  a_sleep_take: assert property (
    mode_out == 3'h0 && sleep_exec && clk_en && !cpu_hold |-> ##2 mode_out != 3'h0)
    else $error("sleep not taken");

  c_standby: cover property (mode_out == 3'h6 ##1 wake_irq);
  c_watch: cover property (mode_out == 3'h5 ##1 mode_out == 3'h2);
  c_medium: cover property (mode_out == 3'h1 && osc_div == 7'h40);
endmodule // pdm_mode_sva

bind pdm_mode_ctrl pdm_mode_sva pdm_mode_sva_inst (.core_clk, .nrst, .clk_en, .sleep_exec,
  .wake_irq, .cpu_hold, .periph_hold, .osc_run, .sub_clk_sel, .osc_div, .mode_out);

`default_nettype wire

/* File: verif/power_down_mode_control_tb.sv */
/*
  Self-checking bench of the power-down mode control block.
  Assumes pdm_mode_ctrl and its checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

module power_down_mode_control_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_exec = 1'b0;
  logic wake_irq = 1'b0;
  logic [7:0] reg_rdata;
  logic cpu_hold, periph_hold, osc_run, sub_clk_sel;
  logic [6:0] osc_div;
  logic [2:0] mode_out;
  logic [7:0] v, e;
  logic [31:0] rng = 32'h17;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  int waits[8] = '{8192, 16384, 1024, 2048, 4096, 256, 512, 16};

  always #2 core_clk = ~core_clk;

  pdm_mode_ctrl pdm_mode_ctrl_inst (.core_clk, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .sleep_exec, .wake_irq, .cpu_hold, .periph_hold, .osc_run,
    .sub_clk_sel, .osc_div, .mode_out);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  // Sleep (s=1) or wake (s=0) pulse, returns at the taking edge
  task automatic pulse(input logic s);
    @(posedge core_clk);
    if (s) sleep_exec <= 1'b1;
    else wake_irq <= 1'b1;
    @(posedge core_clk);
    sleep_exec <= 1'b0;
    wake_irq <= 1'b0;
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk({mode_out, osc_div, osc_run, cpu_hold}, {3'h0, 7'h01, 2'b10});
    rd(4'h0, v);
    chk(v, 8'h03);
    rd(4'h1, v);
    chk(v, 8'h00);
    for (int w = 0; w < 8; w++) begin
      e = {1'b1, w[2:0], 1'b0, w[2], w[1:0]};
      wr(4'h0, e);
      rd(4'h0, v);
      chk(v, e);
      rng = xs(rng);
      wr(4'h1, (rng[7:0] & 8'hf3) | 8'h04);
      rd(4'h1, v);
      chk(v, 8'h04);
      pulse(1'b1);
      settle(2);
      chk({mode_out, cpu_hold, periph_hold, osc_run}, {w[2] ? 3'h5 : 3'h6, 1'b1, ~w[2], 1'b0});
      pulse(1'b0);
      n = 0;
      do begin
        @(negedge core_clk);
        n++;
      end while (cpu_hold !== 1'b0 && n < 20000);
      chk(n >= waits[w] + 1 && n <= waits[w] + 4, 1);
      settle(0);
      chk({mode_out, osc_div, periph_hold, sub_clk_sel}, {3'h1, 7'h08 << w[1:0], 2'b00});
      wr(4'h0, {1'b0, w[2:0], 2'b00, ~w[1:0]});
      rd(4'h0, v);
      chk(v, {1'b0, w[2:0], 2'b00, w[1:0]});
      wr(4'h1, 8'h00);
      pulse(1'b1);
      settle(2);
      chk({mode_out, cpu_hold, osc_run}, {3'h3, 2'b11});
      pulse(1'b0);
      settle(3);
      chk({mode_out, osc_div, cpu_hold}, {3'h0, 7'h01, 1'b0});
    end
    wr(4'h0, 8'hfc);
    pulse(1'b1);
    settle(2);
    chk(mode_out, 3'h5);
    pulse(1'b0);
    settle(3);
    chk({mode_out, sub_clk_sel, cpu_hold}, {3'h2, 2'b10});
    // Frozen clock enable drops a sleep request
    @(posedge core_clk);
    clk_en <= 1'b0;
    sleep_exec <= 1'b1;
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    sleep_exec <= 1'b0;
    settle(2);
    chk(mode_out, 3'h2);
    // Command register sleep and wake
    wr(4'h3, 8'h01);
    settle(2);
    chk(mode_out, 3'h5);
    wr(4'h3, 8'h02);
    settle(2);
    chk(mode_out, 3'h2);
    rd(4'h2, v);
    chk(v, 8'h02);
    rng = xs(rng);
    wr(4'h9, rng[7:0]);
    rd(4'h9, v);
    chk(v, 8'h00);
    rd(4'h0, v);
    chk(v, 8'hfc);
    summarize();
  end
endmodule // power_down_mode_control_tb

`default_nettype wire
